// ### logic/seep_cmd_port.sv
// Purpose: Slave command front end of a 16 x 16-bit serial EEPROM.
// Assumes: clk_sys is far faster than the serial clock; pins are asynchronous.
// Notes:   Serial clock edges are found by sampling, so no second clock domain.
// Function
// - Chip select high selects; low ignores everything.
// - Chip select rise resets the command machine.
// - Sample DI and update DO on SK rise.
// - Drive DO only while selected.
// - Protect-select picks array or guard instructions.
// - Program-enable pin gates all write-type operations except write-lock.
// - Skip leading zeros; one start bit begins.
// - Two opcode bits follow start; full decode.
// - Six address bits; low four pick word.
// - Sixteen data bits, most significant first.
// - Chip select fall launches timed programming; busy.
// - Array opcodes: read, write, control by address.
// - Guard opcodes decoded with protect-select high.
// - Read: dummy zero, then bits 15 to 0.
// - Continued clocking streams next word, no dummy.
// - Write latch clear at reset; gates programming.
// - Write-unlock sets latch at chip select fall.
// - Read ignores and keeps the write latch.
// - After a launch, selected DO shows 0 while busy, then 1 until the next start bit.
// - Words at or above guard start refuse writes.
`timescale 1ns/1ps
`include "seep_defs.svh"

module seep_cmd_port #(
  parameter int WP_CYCLES = `SEEP_TWP_US * `SEEP_CLK_MHZ
) (
  input  wire logic                 clk_sys,
  input  wire logic                 resetn,
  input  wire seep_pkg::seep_pins_t pins,
  output logic                      do_out,
  output logic                      do_oe,
  output seep_pkg::seep_status_t    status
);
  import seep_pkg::*;

  localparam int WPW = $clog2(WP_CYCLES + 1);

  seep_pins_t                  pin_q;
  logic                        sk_d_reg;
  logic                        cs_d_reg;
  logic                        sk_rise;
  logic                        cs_rise;
  logic                        cs_fall;
  seep_state_t                 state_reg;
  logic [4:0]                  cnt_reg;
  logic                        last_bit;
  logic [1:0]                  opc_reg;
  logic [4:0]                  addr_reg;
  logic [5:0]                  addr_full;
  logic [5:0]                  cmd_addr_reg;
  logic [`SEEP_WORD_BITS-1:0]  data_reg;
  seep_instr_t                 instr_now;
  seep_instr_t                 instr_reg;
  logic [`SEEP_WORD_BITS-1:0]  mem_reg [`SEEP_WORDS];
  logic [`SEEP_WORD_BITS-1:0]  out_sr_reg;
  logic [`SEEP_PTR_BITS-1:0]   ptr_reg;
  logic                        do_reg;
  logic                        poll_reg;
  logic                        wel_reg;
  logic                        guard_en_reg;
  logic                        guard_locked_reg;
  logic [`SEEP_GUARD_BITS-1:0] guard_reg;
  logic [WPW-1:0]              wp_cnt_reg;
  logic                        busy;
  logic                        commit;
  logic                        prog_ok;
  logic                        launch;

  seep_sync #(
    .W ($bits(seep_pins_t))
  ) u_sync (
    .clk_sys (clk_sys),
    .resetn  (resetn),
    .d       (pins),
    .q       (pin_q)
  );

  // Decodes the instruction from protect-select, opcode and full address.
  function automatic seep_instr_t seep_decode(input logic       gsel,
                                              input logic [1:0] opc,
                                              input logic [5:0] adr);
    seep_instr_t r;
    r = IN_NONE;
    if (!gsel) begin
      case (opc)
        `SEEP_OPC_READ:  r = IN_READ;
        `SEEP_OPC_WRITE: r = IN_WRITE;
        `SEEP_OPC_CTRL: begin
          case (adr[5:4])
            `SEEP_AHI_UNLOCK: r = IN_WRITE_UNLOCK;
            `SEEP_AHI_FILL:   r = IN_FILL_ALL;
            `SEEP_AHI_LOCK:   r = IN_WRITE_LOCK;
            default:          r = IN_NONE;
          endcase
        end
        default: r = IN_NONE;
      endcase
    end else begin
      case (opc)
        `SEEP_OPC_READ:  r = IN_GUARD_READ;
        `SEEP_OPC_WRITE: r = IN_GUARD_SET;
        `SEEP_OPC_GCLR:  r = (adr == `SEEP_ADDR_ONES) ? IN_GUARD_CLEAR : IN_NONE;
        `SEEP_OPC_CTRL: begin
          if (adr[5:4] == `SEEP_AHI_UNLOCK) begin
            r = IN_GUARD_UNLOCK;
          end else if (adr == `SEEP_ADDR_ZERO) begin
            r = IN_GUARD_LOCK;
          end else begin
            r = IN_NONE;
          end
        end
        default: r = IN_NONE;
      endcase
    end
    return r;
  endfunction : seep_decode

  // Edge detection runs on synchronised copies only.
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      sk_d_reg <= 1'b0;
      cs_d_reg <= 1'b0;
    end else begin
      sk_d_reg <= pin_q.sk;
      cs_d_reg <= pin_q.cs;
    end
  end

  assign sk_rise = pin_q.cs & pin_q.sk & ~sk_d_reg;
  assign cs_rise = pin_q.cs & ~cs_d_reg;
  assign cs_fall = ~pin_q.cs & cs_d_reg;

  assign addr_full = {addr_reg, pin_q.di};
  assign instr_now = seep_decode(pin_q.guard_sel, opc_reg, addr_full);
  assign busy      = (wp_cnt_reg != '0);

  always_comb begin
    case (state_reg)
      ST_OPC:  last_bit = (cnt_reg == `SEEP_OPC_LAST);
      ST_ADDR: last_bit = (cnt_reg == `SEEP_ADDR_LAST);
      ST_DATA: last_bit = (cnt_reg == `SEEP_DATA_LAST);
      ST_READ: last_bit = (instr_reg == IN_GUARD_READ) ?
                          (cnt_reg == `SEEP_GREAD_LAST) : (cnt_reg == `SEEP_WORD_LAST);
      default: last_bit = 1'b0;
    endcase
  end

  // Command sequencer.
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      state_reg <= ST_IDLE;
    end else if (cs_rise) begin
      state_reg <= ST_IDLE;
    end else if (sk_rise) begin
      case (state_reg)
        ST_IDLE: begin
          // A new instruction is held off while programming runs.
          if (pin_q.di && !busy) begin
            state_reg <= ST_OPC;
          end
        end
        ST_OPC: begin
          if (last_bit) begin
            state_reg <= ST_ADDR;
          end
        end
        ST_ADDR: begin
          if (last_bit) begin
            case (instr_now)
              IN_READ, IN_GUARD_READ: state_reg <= ST_READ;
              IN_WRITE, IN_FILL_ALL:  state_reg <= ST_DATA;
              default:                state_reg <= ST_DONE;
            endcase
          end
        end
        ST_DATA: begin
          if (last_bit) begin
            state_reg <= ST_DONE;
          end
        end
        ST_READ: begin
          if (last_bit && instr_reg == IN_GUARD_READ) begin
            state_reg <= ST_DONE;
          end
        end
        // A clock after the last field cancels the pending instruction.
        ST_DONE: state_reg <= ST_SINK;
        ST_SINK: state_reg <= ST_SINK;
        default: state_reg <= ST_IDLE;
      endcase
    end
  end

  // Field bit counter; sequential read wraps it at each word.
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      cnt_reg <= 5'h00;
    end else if (cs_rise) begin
      cnt_reg <= 5'h00;
    end else if (sk_rise) begin
      if (last_bit || state_reg == ST_IDLE) begin
        cnt_reg <= 5'h00;
      end else begin
        cnt_reg <= cnt_reg + 5'h01;
      end
    end
  end

  // Input shift registers, most significant bit first.
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      opc_reg      <= 2'h0;
      addr_reg     <= 5'h00;
      cmd_addr_reg <= 6'h00;
      data_reg     <= '0;
      instr_reg    <= IN_NONE;
    end else if (cs_rise) begin
      instr_reg <= IN_NONE;
    end else if (sk_rise) begin
      case (state_reg)
        ST_OPC:  opc_reg <= {opc_reg[0], pin_q.di};
        ST_ADDR: begin
          addr_reg <= addr_full[4:0];
          if (last_bit) begin
            cmd_addr_reg <= addr_full;
            instr_reg    <= instr_now;
          end
        end
        ST_DATA: data_reg <= {data_reg[`SEEP_WORD_BITS-2:0], pin_q.di};
        default: opc_reg <= opc_reg;
      endcase
    end
  end

  // Output path; read data on DO changes just after a serial clock rise, and chip select rise clears it to 0.
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      do_reg     <= 1'b0;
      out_sr_reg <= '0;
      ptr_reg    <= '0;
    end else if (cs_rise) begin
      do_reg <= 1'b0;
    end else if (sk_rise) begin
      if (state_reg == ST_ADDR && last_bit && instr_now == IN_READ) begin
        out_sr_reg <= mem_reg[addr_full[`SEEP_PTR_BITS-1:0]];
        ptr_reg    <= addr_full[`SEEP_PTR_BITS-1:0];
        do_reg     <= 1'b0;
      end else if (state_reg == ST_ADDR && last_bit && instr_now == IN_GUARD_READ) begin
        out_sr_reg <= {guard_reg, `SEEP_GUARD_PAD};
        do_reg     <= 1'b0;
      end else if (state_reg == ST_READ) begin
        do_reg <= out_sr_reg[`SEEP_WORD_BITS-1];
        if (last_bit && instr_reg == IN_READ) begin
          ptr_reg    <= ptr_reg + 1'b1;
          out_sr_reg <= mem_reg[ptr_reg + 1'b1];
        end else begin
          out_sr_reg <= {out_sr_reg[`SEEP_WORD_BITS-2:0], 1'b0};
        end
      end else begin
        do_reg <= 1'b0;
      end
    end
  end

  // Status polling follows a launch until the next start bit.
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      poll_reg <= 1'b0;
    end else if (launch) begin
      poll_reg <= 1'b1;
    end else if (sk_rise && state_reg == ST_IDLE && pin_q.di && !busy) begin
      poll_reg <= 1'b0;
    end
  end

  assign do_oe  = pin_q.cs;
  assign do_out = pin_q.cs & (poll_reg ? ~busy : do_reg);

  // Only a fully clocked instruction commits, and only when select falls.
  assign commit  = cs_fall && state_reg == ST_DONE;
  assign prog_ok = pin_q.program_enable_pin && wel_reg;

  always_comb begin
    case (instr_reg)
      IN_WRITE:       launch = commit && prog_ok && !pin_q.guard_sel &&
                               ({2'b00, cmd_addr_reg[3:0]} < guard_reg);
      IN_FILL_ALL:    launch = commit && prog_ok && guard_reg == `SEEP_GUARD_RST;
      IN_GUARD_CLEAR: launch = commit && prog_ok && guard_en_reg && !guard_locked_reg;
      IN_GUARD_SET:   launch = commit && prog_ok && guard_en_reg && !guard_locked_reg &&
                               guard_reg == `SEEP_GUARD_RST;
      IN_GUARD_LOCK:  launch = commit && prog_ok && guard_en_reg && !guard_locked_reg;
      default:        launch = 1'b0;
    endcase
  end

  // Self-timed programming window.
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      wp_cnt_reg <= '0;
    end else if (launch) begin
      wp_cnt_reg <= WPW'(WP_CYCLES);
    end else if (busy) begin
      wp_cnt_reg <= wp_cnt_reg - 1'b1;
    end
  end

  // Array contents; written at the launch of programming.
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      for (int i = 0; i < `SEEP_WORDS; i++) begin
        mem_reg[i] <= '0;
      end
    end else if (launch && instr_reg == IN_WRITE) begin
      mem_reg[cmd_addr_reg[`SEEP_PTR_BITS-1:0]] <= data_reg;
    end else if (launch && instr_reg == IN_FILL_ALL) begin
      for (int i = 0; i < `SEEP_WORDS; i++) begin
        mem_reg[i] <= data_reg;
      end
    end
  end

  // Write-enable latch; reads never touch it.
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      wel_reg <= 1'b0;
    end else if (commit && instr_reg == IN_WRITE_UNLOCK && pin_q.program_enable_pin) begin
      wel_reg <= 1'b1;
    end else if (commit && instr_reg == IN_WRITE_LOCK) begin
      wel_reg <= 1'b0;
    end
  end

  // Guard enable lasts exactly one following instruction.
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      guard_en_reg <= 1'b0;
    end else if (cs_fall && state_reg != ST_IDLE) begin
      guard_en_reg <= commit && instr_reg == IN_GUARD_UNLOCK && prog_ok;
    end
  end

  // Guard start address and its permanent lock.
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      guard_reg        <= `SEEP_GUARD_RST;
      guard_locked_reg <= 1'b0;
    end else if (launch) begin
      case (instr_reg)
        IN_GUARD_CLEAR: guard_reg        <= `SEEP_GUARD_RST;
        IN_GUARD_SET:   guard_reg        <= {2'b00, cmd_addr_reg[3:0]};
        IN_GUARD_LOCK:  guard_locked_reg <= 1'b1;
        default:        guard_reg        <= guard_reg;
      endcase
    end
  end

  always_comb begin
    status.busy         = busy;
    status.write_en     = wel_reg;
    status.guard_en     = guard_en_reg;
    status.guard_locked = guard_locked_reg;
    status.guard_start  = guard_reg;
  end

endmodule : seep_cmd_port

// ### logic/seep_defs.svh
// Purpose: Named constants for the serial EEPROM command port.
// Assumes: Included by the package and the command port module.
// Notes:   Field widths and opcode encodings of the serial instruction format.
`ifndef SEEP_DEFS_SVH
`define SEEP_DEFS_SVH

`define SEEP_WORDS        16
`define SEEP_WORD_BITS    16
`define SEEP_PTR_BITS     4
`define SEEP_GUARD_BITS   6
`define SEEP_OPC_LAST     5'h01
`define SEEP_ADDR_LAST    5'h05
`define SEEP_DATA_LAST    5'h0f
`define SEEP_WORD_LAST    5'h0f
`define SEEP_GREAD_LAST   5'h05
`define SEEP_OPC_READ     2'h2
`define SEEP_OPC_WRITE    2'h1
`define SEEP_OPC_CTRL     2'h0
`define SEEP_OPC_GCLR     2'h3
`define SEEP_AHI_UNLOCK   2'h3
`define SEEP_AHI_FILL     2'h1
`define SEEP_AHI_LOCK     2'h0
`define SEEP_ADDR_ONES    6'h3f
`define SEEP_ADDR_ZERO    6'h00
`define SEEP_GUARD_RST    6'h3f
`define SEEP_GUARD_PAD    10'h000
`define SEEP_TWP_US       15000
`define SEEP_CLK_MHZ      125

`endif

// ### logic/seep_pkg.sv
// Purpose: Types shared by the serial EEPROM command port.
// Assumes: seep_defs.svh supplies the widths.
// Notes:   Pin and status groups travel as packed structs.
`include "seep_defs.svh"

package seep_pkg;

  typedef struct packed {
    logic cs;
    logic sk;
    logic di;
    logic guard_sel;
    logic program_enable_pin;
  } seep_pins_t;

  typedef struct packed {
    logic                        busy;
    logic                        write_en;
    logic                        guard_en;
    logic                        guard_locked;
    logic [`SEEP_GUARD_BITS-1:0] guard_start;
  } seep_status_t;

  typedef enum logic [6:0] {
    ST_IDLE = 7'h01,
    ST_OPC  = 7'h02,
    ST_ADDR = 7'h04,
    ST_DATA = 7'h08,
    ST_READ = 7'h10,
    ST_DONE = 7'h20,
    ST_SINK = 7'h40
  } seep_state_t;

  typedef enum logic [3:0] {
    IN_NONE         = 4'h0,
    IN_READ         = 4'h1,
    IN_WRITE_UNLOCK = 4'h2,
    IN_WRITE        = 4'h3,
    IN_FILL_ALL     = 4'h4,
    IN_WRITE_LOCK   = 4'h5,
    IN_GUARD_READ   = 4'h6,
    IN_GUARD_UNLOCK = 4'h7,
    IN_GUARD_CLEAR  = 4'h8,
    IN_GUARD_SET    = 4'h9,
    IN_GUARD_LOCK   = 4'ha
  } seep_instr_t;

endpackage : seep_pkg

// ### logic/seep_sync.sv
// Purpose: Two-stage synchroniser for pins entering the system clock domain.
// Assumes: Inputs are asynchronous to clk_sys.
// Notes:   Only the second stage is visible outside.
`timescale 1ns/1ps

module seep_sync #(
  parameter int W = 1
) (
  input  wire logic         clk_sys,
  input  wire logic         resetn,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);

  logic [W-1:0] meta_reg;

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      meta_reg <= '0;
      q        <= '0;
    end else begin
      meta_reg <= d;
      q        <= meta_reg;
    end
  end

endmodule : seep_sync

// ### verif/seep_host.sv
// Purpose: Serial bus master that drives the command port pins.
// Assumes: Called from the bench; all pin changes land 1 ns after a clk_sys edge.
// Notes:   The serial clock stands low between frames.
`timescale 1ns/1ps

module seep_host (
  input  wire logic         clk_sys,
  input  wire logic         do_out,
  output seep_pkg::seep_pins_t pins
);
  import seep_pkg::*;

  initial pins = '0;

  task automatic tick(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask : tick

  // Bits go out MSB first; every sample is taken at the end of the low phase.
  task automatic frame(input logic gs, input logic pe, input logic [31:0] cmd,
                       input int n, input int nrd, output logic [63:0] rd);
    pins.guard_sel          = gs;
    pins.program_enable_pin = pe;
    pins.cs                 = 1'b1;
    rd                      = '0;
    for (int i = 0; i < n + nrd; i++) begin
      pins.di = (i < n) ? cmd[n-1-i] : 1'b0;
      tick(5);
      rd      = {rd[62:0], do_out};
      pins.sk = 1'b1;
      tick(5);
      pins.sk = 1'b0;
    end
    tick(5);
    rd      = {rd[62:0], do_out};
    // The select drops between every frame; data in goes to a fresh level.
    pins.cs = 1'b0;
    pins.di = ~pins.di;
    tick(10);
  endtask : frame

  // Status is read with no serial clock at all.
  task automatic poll(output logic first, output logic last);
    pins.cs = 1'b1;
    tick(4);
    first = do_out;
    for (int i = 0; i < 200 && do_out !== 1'b1; i++) tick(1);
    last    = do_out;
    pins.cs = 1'b0;
    tick(10);
  endtask : poll
endmodule : seep_host

// ### verif/seep_cmd_port_monitor.sv
// Purpose: Concurrent checks on the command port pins and status.
// Assumes: WP_CYCLES matches the design instance.
// Notes:   Attached by bind to every command port instance.
`timescale 1ns/1ps

module seep_cmd_port_monitor #(
  parameter int WP_CYCLES = 40
) (
  input wire logic                 clk_sys,
  input wire logic                 resetn,
  input wire seep_pkg::seep_pins_t pins,
  input wire logic                 do_out,
  input wire logic                 do_oe,
  input wire seep_pkg::seep_status_t status
);
  import seep_pkg::*;
  logic [31:0] busy_cnt_reg;

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!resetn);

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) busy_cnt_reg <= 32'h0;
    else busy_cnt_reg <= status.busy ? busy_cnt_reg + 32'h1 : 32'h0;
  end

  property p_oe_on;      pins.cs [*3] |-> do_oe; endproperty
  property p_oe_off;     !pins.cs [*3] |-> !do_oe && !do_out; endproperty
  property p_busy_len;   $fell(status.busy) |-> busy_cnt_reg == WP_CYCLES; endproperty
  property p_busy_start; $rose(status.busy) |-> !$past(pins.cs, 1) && !$past(pins.cs, 2);
  endproperty
  property p_busy_wen;   $rose(status.busy) |-> status.write_en; endproperty
  property p_poll;       status.busy && do_oe |-> !do_out; endproperty
  property p_wen_rise;   $rose(status.write_en) |-> !do_oe && $past(pins.program_enable_pin);
  endproperty
  property p_wen_fall;   $fell(status.write_en) |-> !do_oe; endproperty
  property p_guard_chg;  $changed(status.guard_start) |-> !do_oe && pins.program_enable_pin;
  endproperty

  a_oe_on:      assert property (p_oe_on) else $error("enable missing while selected");
  a_oe_off:     assert property (p_oe_off) else $error("output active while deselected");
  a_busy_len:   assert property (p_busy_len) else $error("busy length wrong");
  a_busy_start: assert property (p_busy_start) else $error("busy began while selected");
  a_poll:       assert property (p_poll) else $error("ready shown while busy");
  a_wen_rise:   assert property (p_wen_rise) else $error("write latch set wrongly");
  a_wen_fall:   assert property (p_wen_fall) else $error("write latch cleared mid frame");
  a_guard_chg:  assert property (p_guard_chg) else $error("guard start changed wrongly");
  a_busy_wen:   assert property (p_busy_wen) else $error("programming while latch clear");

  c_busy:  cover property ($rose(status.busy));
  c_wen:   cover property ($fell(status.write_en));
  c_guard: cover property ($changed(status.guard_start));
  c_lock:  cover property ($rose(status.guard_locked));
endmodule : seep_cmd_port_monitor

bind seep_cmd_port seep_cmd_port_monitor #(.WP_CYCLES(WP_CYCLES)) u_mon (
  .clk_sys(clk_sys), .resetn(resetn), .pins(pins), .do_out(do_out), .do_oe(do_oe),
  .status(status));

// ### verif/testbench.sv
// Purpose: Self-checking bench for the serial command port.
// Assumes: Programming time shortened to 40 cycles.
// Notes:   Serial clock period is 80 ns, ten system cycles.
`timescale 1ns/1ps

module testbench;
  import seep_pkg::*;
  logic                 clk_sys;
  logic                 resetn;
  seep_pins_t           pins;
  logic                 do_out;
  logic                 do_oe;
  seep_status_t         status;
  logic [63:0]          rd;
  logic                 p0;
  logic                 p1;
  int                   err_count;
  int                   tests_run;
  int                   cycles;

  seep_cmd_port #(.WP_CYCLES(40)) u_dut (
    .clk_sys(clk_sys), .resetn(resetn), .pins(pins), .do_out(do_out), .do_oe(do_oe),
    .status(status));
  seep_host u_host (.clk_sys(clk_sys), .do_out(do_out), .pins(pins));

  initial begin
    clk_sys = 1'b0;
    forever #4 clk_sys = ~clk_sys;
  end

  task automatic check(input string what, input logic [63:0] exp, input logic [63:0] got);
    tests_run++;
    if (got !== exp) begin
      err_count++;
      $display("unexpected %s: expected %h seen %h", what, exp, got);
    end
  endtask : check

  task automatic close_out();
    $display("checks %0d, mismatches %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : close_out

  // A refused or committed write leaves busy showing the outcome by now.
  task automatic wr(input logic pe, input logic [5:0] a, input logic [15:0] d, input logic bsy);
    u_host.frame(1'b0, pe, {1'b1, 2'b01, a, d}, 25, 0, rd);
    check("busy after write", {63'h0, bsy}, {63'h0, status.busy});
    if (bsy) begin
      u_host.poll(p0, p1);
      check("poll busy then ready", 64'h1, {62'h0, p0, p1});
    end
  endtask : wr

  task automatic rd_word(input logic [5:0] a, input logic [15:0] d);
    u_host.frame(1'b0, 1'b0, {1'b1, 2'b10, a}, 9, 16, rd);
    check("read word", {48'h0, d}, rd[63:0] & 64'h1_ffff);
  endtask : rd_word

  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == 20000) begin
      err_count++;
      close_out();
    end
  end

  initial begin
    err_count = 0;
    tests_run = 0;
    cycles    = 0;
    resetn    = 1'b0;
    repeat (10) @(posedge clk_sys);
    #1 resetn = 1'b1;
    u_host.tick(2);
    check("reset status", {54'h0, 4'h0, 6'h3f}, {54'h0, status.busy, status.write_en,
          status.guard_en, status.guard_locked, status.guard_start});
    check("oe deselected", 64'h0, {63'h0, do_oe});
    wr(1'b1, 6'h0f, 16'ha5c3, 1'b0);
    $display("test locked write done");
    u_host.frame(1'b0, 1'b1, {3'b000, 1'b1, 2'b00, 6'h30}, 12, 0, rd);
    check("latch after unlock", 64'h1, {63'h0, status.write_en});
    wr(1'b0, 6'h0f, 16'h1234, 1'b0);
    wr(1'b1, 6'h2f, 16'ha5c3, 1'b1);
    u_host.frame(1'b0, 1'b0, {1'b1, 2'b10, 6'h3f}, 9, 32, rd);
    check("sequential wrap", {32'h0, 16'ha5c3, 16'h0}, rd & 64'h1_ffff_ffff);
    check("latch kept by read", 64'h1, {63'h0, status.write_en});
    $display("test write and sequential read done");
    u_host.frame(1'b0, 1'b1, {1'b1, 2'b00, 6'h10, 16'h0f0f}, 25, 0, rd);
    u_host.poll(p0, p1);
    check("fill poll", 64'h1, {62'h0, p0, p1});
    rd_word(6'h07, 16'h0f0f);
    // A write cut off before any of its data bits must not launch programming.
    u_host.frame(1'b0, 1'b1, {1'b1, 2'b01, 6'h01}, 9, 0, rd);
    check("cut write busy", 64'h0, {63'h0, status.busy});
    $display("test fill done");
    u_host.frame(1'b1, 1'b1, {1'b1, 2'b00, 6'h30}, 9, 0, rd);
    u_host.frame(1'b1, 1'b1, {1'b1, 2'b01, 6'h08}, 9, 0, rd);
    u_host.poll(p0, p1);
    check("guard start", 64'h08, {58'h0, status.guard_start});
    u_host.frame(1'b1, 1'b0, {1'b1, 2'b10, 6'h00}, 9, 6, rd);
    check("guard read", 64'h08, rd & 64'h7f);
    wr(1'b1, 6'h09, 16'hffff, 1'b0);
    rd_word(6'h09, 16'h0f0f);
    $display("test guard done");
    u_host.frame(1'b1, 1'b0, {1'b1, 2'b00, 6'h30}, 9, 0, rd);
    check("guard unlock without pe", 64'h0, {63'h0, status.guard_en});
    u_host.frame(1'b1, 1'b1, {1'b1, 2'b00, 6'h30}, 9, 0, rd);
    check("guard unlock", 64'h1, {63'h0, status.guard_en});
    u_host.frame(1'b1, 1'b1, {1'b1, 2'b11, 6'h3f}, 9, 0, rd);
    u_host.poll(p0, p1);
    check("guard clear", {56'h0, 2'b01, 6'h3f}, {56'h0, p0, p1, status.guard_start});
    u_host.frame(1'b1, 1'b1, {1'b1, 2'b00, 6'h30}, 9, 0, rd);
    u_host.frame(1'b1, 1'b1, {1'b1, 2'b00, 6'h00}, 9, 0, rd);
    u_host.poll(p0, p1);
    check("guard lock", 64'h3, {61'h0, p0, p1, status.guard_locked});
    // Once locked, an armed guard-set must be refused and leave the start alone.
    u_host.frame(1'b1, 1'b1, {1'b1, 2'b00, 6'h30}, 9, 0, rd);
    u_host.frame(1'b1, 1'b1, {1'b1, 2'b01, 6'h02}, 9, 0, rd);
    check("set after lock", 64'h3f, {57'h0, status.busy, status.guard_start});
    $display("test guard clear and lock done");
    u_host.frame(1'b0, 1'b0, {1'b1, 2'b00, 6'h00}, 9, 0, rd);
    check("latch after lock", 64'h0, {63'h0, status.write_en});
    rd_word(6'h07, 16'h0f0f);
    $display("test lock done");
    close_out();
  end
endmodule : testbench
